// File: osc_pkg.sv
// Constants and types for the oscillator source control block
package osc_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    // Start-up waits in microseconds
    localparam int unsigned SPEEDUP_WAIT_US  = 1000;
    localparam int unsigned LOWPWR_WAIT_US   = 2000;
    localparam int unsigned SPEEDUP_CYCLES   = SPEEDUP_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LOWPWR_CYCLES    = LOWPWR_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W            = 17;

    localparam logic        FAST_SEL_RST     = 1'b0;
    localparam logic        SLOW_SEL_RST     = 1'b0;
    localparam logic        DRIVE_MODE_RST   = 1'b0;

    typedef enum logic [1:0]
    {
        OSC_EXT_FAST = 2'b00,
        OSC_INT_FAST = 2'b01,
        OSC_EXT_SLOW = 2'b10,
        OSC_INT_SLOW = 2'b11
    } osc_src_t;

    typedef struct packed
    {
        logic fast_source_select;
        logic slow_source_select;
        logic use_slow_clock;
        logic slow_crystal_enable;
        logic slow_crystal_drive_mode;
        logic sleep_req;
        logic slow_keep_in_idle;
    } osc_ctrl_t;

    typedef struct packed
    {
        osc_src_t sys_source;
        logic     sys_clk_on;
        logic     slow_clk_on;
        logic     slow_crystal_ready;
        logic     drive_mode;
        logic     drive_locked;
        logic     slow_pins_to_crystal;
        logic     fast_pins_to_crystal;
    } osc_stat_t;

endpackage : osc_pkg

// File: osc_startup_timer.sv
// Slow crystal start-up wait counter
`timescale 1ns/1ps
`default_nettype none
module osc_startup_timer
(
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic enable_i,
    input  wire logic speedup_i,
    output logic      ready_o
);
    import osc_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic             ready_d;

    // Low-power mode waits longer
    assign limit   = speedup_i ? CNT_W'(SPEEDUP_CYCLES) : CNT_W'(LOWPWR_CYCLES);
    assign ready_d = enable_i && (ready_o || (cnt_q >= limit - 1'b1));
    assign cnt_d   = (!enable_i || ready_o) ? '0 : cnt_q + 1'b1;

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q   <= '0;
            ready_o <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            ready_o <= ready_d;
        end
    end
endmodule : osc_startup_timer
`default_nettype wire

// File: osc_source_ctrl.sv
// Oscillator source selection, drive mode lock and pin hand-over
`timescale 1ns/1ps
`default_nettype none
module osc_source_ctrl
(
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    input  wire osc_pkg::osc_ctrl_t ctrl_i,
    output var  osc_pkg::osc_stat_t stat_o
);
    import osc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registered controls
    logic     fast_sel_q;
    logic     slow_sel_q;
    logic     use_slow_q;
    logic     xtal_en_q;
    logic     drive_q;
    logic     sleep_q;
    logic     keep_q;
    logic     ready;
    logic     lock_now;
    logic     drive_d;
    osc_src_t src_d;

    // Slow crystal drives system clock
    assign lock_now = use_slow_q && !slow_sel_q;
    assign drive_d  = lock_now ? drive_q : ctrl_i.slow_crystal_drive_mode;

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            fast_sel_q <= FAST_SEL_RST;
            slow_sel_q <= SLOW_SEL_RST;
            use_slow_q <= 1'b0;
            xtal_en_q  <= 1'b0;
            drive_q    <= DRIVE_MODE_RST;
            sleep_q    <= 1'b0;
            keep_q     <= 1'b0;
        end
        else
        begin
            fast_sel_q <= ctrl_i.fast_source_select;
            slow_sel_q <= ctrl_i.slow_source_select;
            use_slow_q <= ctrl_i.use_slow_clock;
            xtal_en_q  <= ctrl_i.slow_crystal_enable;
            drive_q    <= drive_d;
            sleep_q    <= ctrl_i.sleep_req;
            keep_q     <= ctrl_i.slow_keep_in_idle;
        end
    end

    osc_startup_timer u_timer
    (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .enable_i  (xtal_en_q),
        .speedup_i (drive_q),
        .ready_o   (ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source selection and outputs
    assign src_d = use_slow_q ? (slow_sel_q ? OSC_INT_SLOW : OSC_EXT_SLOW)
                              : (fast_sel_q ? OSC_INT_FAST : OSC_EXT_FAST);

    always_comb
    begin
        stat_o                      = '0;
        stat_o.sys_source           = src_d;
        stat_o.sys_clk_on           = !sleep_q;
        stat_o.slow_clk_on          = !sleep_q || keep_q;
        stat_o.slow_crystal_ready   = ready;
        stat_o.drive_mode           = drive_q;
        stat_o.drive_locked         = lock_now;
        stat_o.slow_pins_to_crystal = xtal_en_q && !slow_sel_q;
        stat_o.fast_pins_to_crystal = !fast_sel_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Check helpers: start-up wait counted apart from the timer
    logic [CNT_W-1:0] chk_wait_q;
    logic [CNT_W-1:0] chk_wait_d;
    logic             chk_wait_full;
    logic             chk_fast_q;
    logic             chk_fast_d;

    assign chk_wait_full = (chk_wait_q == CNT_W'(LOWPWR_CYCLES));
    assign chk_wait_d    = !xtal_en_q    ? '0
                         : chk_wait_full ? chk_wait_q
                         : chk_wait_q + 1'b1;
    assign chk_fast_d    = xtal_en_q && (chk_fast_q || drive_q);

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            chk_wait_q <= '0;
            chk_fast_q <= 1'b0;
        end
        else
        begin
            chk_wait_q <= chk_wait_d;
            chk_fast_q <= chk_fast_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequences for the checks: four single-cycle triggers, two consequents one cycle later
    sequence reset_released_s;
        $fell(sys_rst_i);
    endsequence

    sequence crystal_clocks_system_s;
        use_slow_q && !slow_sel_q;
    endsequence

    sequence drive_held_s;
        ##1 $stable(drive_q);
    endsequence

    sequence drop_to_low_power_s;
        xtal_en_q && ready && drive_q && !lock_now && !ctrl_i.slow_crystal_drive_mode;
    endsequence

    sequence still_running_s;
        ##1 ready && !drive_q;
    endsequence

    sequence ready_rises_s;
        $rose(ready);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Checks
    drive_lock_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $past(lock_now) && !$past(sys_rst_i) |-> $stable(drive_q))
        else $error("Drive mode changed while locked");

    fast_pins_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        fast_sel_q |-> !stat_o.fast_pins_to_crystal)
        else $error("Fast pins held with RC selected");

    sleep_clk_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sleep_q |-> !stat_o.sys_clk_on)
        else $error("System clock running in sleep");

    ready_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !xtal_en_q |=> !ready)
        else $error("Ready without enable");

    slow_src_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        use_slow_q && slow_sel_q |-> stat_o.sys_source == OSC_INT_SLOW)
        else $error("Wrong slow source");

    fast_src_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !use_slow_q && !fast_sel_q |-> stat_o.sys_source == OSC_EXT_FAST)
        else $error("Wrong fast source");

    slow_pins_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !xtal_en_q |-> !stat_o.slow_pins_to_crystal)
        else $error("Slow pins held while unused");

    drive_follow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !lock_now |=> drive_q == $past(ctrl_i.slow_crystal_drive_mode))
        else $error("Drive mode not following control");

    reset_default_a: assert property (@(posedge mclk_i)
        reset_released_s |-> stat_o.sys_source == OSC_EXT_FAST
                             && stat_o.fast_pins_to_crystal && !stat_o.drive_mode)
        else $error("Defaults missing after reset");

    drive_frozen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        crystal_clocks_system_s |-> drive_held_s)
        else $error("Drive mode moved while crystal clocks system");

    ext_slow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        crystal_clocks_system_s |-> stat_o.sys_source == OSC_EXT_SLOW && stat_o.drive_locked)
        else $error("Slow crystal not shown as locked source");

    drop_keeps_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        drop_to_low_power_s |-> still_running_s)
        else $error("Crystal stopped after drop to low power");

    ready_early_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ready_rises_s |-> chk_wait_q >= CNT_W'(SPEEDUP_CYCLES))
        else $error("Ready before start-up wait");

    ready_lowpwr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ready_rises_s |-> chk_fast_q || (chk_wait_q >= CNT_W'(LOWPWR_CYCLES)))
        else $error("Low-power start-up too short");

    ready_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        xtal_en_q && ready |=> ready)
        else $error("Ready dropped while enabled");

    int_fast_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !use_slow_q && fast_sel_q |-> stat_o.sys_source == OSC_INT_FAST)
        else $error("Internal fast source not used");

    fast_free_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        stat_o.sys_source == OSC_INT_FAST |-> !stat_o.fast_pins_to_crystal)
        else $error("Fast pins not freed");

    slow_pins_on_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        xtal_en_q && !slow_sel_q |-> stat_o.slow_pins_to_crystal)
        else $error("Slow pins not given to crystal");

    rc_pins_free_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        slow_sel_q |-> !stat_o.slow_pins_to_crystal)
        else $error("Slow pins held with RC selected");

    slow_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sleep_q && keep_q |-> stat_o.slow_clk_on)
        else $error("Slow clock stopped though kept");

    slow_stop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sleep_q && !keep_q |-> !stat_o.slow_clk_on)
        else $error("Slow clock running in sleep");

    awake_clk_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !sleep_q |-> stat_o.sys_clk_on && stat_o.slow_clk_on)
        else $error("Clock stopped while awake");

    speedup_mode_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !lock_now && ctrl_i.slow_crystal_drive_mode |=> stat_o.drive_mode)
        else $error("Speed-up mode not taken");

    locked_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !use_slow_q |-> !stat_o.drive_locked)
        else $error("Drive mode locked on fast source");
endmodule : osc_source_ctrl
`default_nettype wire

// File: osc_source_ctrl_test.sv
// Self-checking bench for the oscillator source control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("unexpected at %0t got %h exp %h", $time, g, e); \
        end \
    end
module osc_source_ctrl_test;
    import osc_pkg::*;
    logic        mclk_i      = 1'b0;
    logic        sys_rst_i   = 1'b1;
    osc_ctrl_t   ctrl        = '0;
    osc_stat_t   st;
    int          n_errors    = 0;
    int          check_count = 0;
    // Rows: control bits in [15:9], expected status in [8:0]
    logic [15:0] rows [6]    = '{16'h0061, 16'h80E0, 16'h0869,
                                 16'hE1E0, 16'h0401, 16'h0621};

    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 mclk_i = ~mclk_i;

    osc_source_ctrl DUT
    (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .ctrl_i    (ctrl),
        .stat_o    (st)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic [6:0] c, input int n);
        @(posedge mclk_i);
        ctrl <= osc_ctrl_t'(c);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK(st, 9'h061)
        $display("test reset done");
        foreach (rows[i])
        begin
            step(rows[i][15:9], 2);
            `CHK(st, rows[i][8:0])
        end
        $display("test table done");
        // Speed-up start, then drop to low power while running
        step(7'h0C, SPEEDUP_CYCLES - 3);
        `CHK(st.slow_crystal_ready, 1'b0)
        repeat (3) @(posedge mclk_i);
        #1;
        `CHK(st.slow_crystal_ready, 1'b0)
        @(posedge mclk_i);
        #1;
        `CHK(st.slow_crystal_ready, 1'b1)
        step(7'h08, 2);
        `CHK({st.drive_mode, st.slow_crystal_ready}, 2'b01)
        // Slow crystal drives the system: drive mode frozen
        step(7'h18, 2);
        `CHK({st.sys_source, st.drive_locked}, 3'b101)
        step(7'h1C, 2);
        `CHK(st.drive_mode, 1'b0)
        step(7'h0C, 2);
        `CHK({st.drive_locked, st.drive_mode}, 2'b01)
        step(7'h00, 2);
        `CHK({st.slow_crystal_ready, st.slow_pins_to_crystal}, 2'b00)
        $display("test speed-up done");
        // Low-power start takes longer than speed-up
        step(7'h08, SPEEDUP_CYCLES + 3);
        `CHK({st.slow_crystal_ready, st.slow_pins_to_crystal}, 2'b01)
        $display("test low-power done");
        // Speed-up after a long low-power wait is ready at once
        step(7'h7F, 2);
        `CHK(st, 9'h1B8)
        // Reset in mid-run returns every output to its default
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK(st, 9'h061)
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        $display("test mid-run reset done");
        complete_run();
    end

    initial
    begin
        repeat (SPEEDUP_CYCLES * 2 + 1000) @(posedge mclk_i);
        n_errors++;
        complete_run();
    end

endmodule : osc_source_ctrl_test
`default_nettype wire
